// >>> core/pbd_map.svh
// register offsets, field positions, reset values and widths of the pwm buffer block
`ifndef PBD_MAP_SVH
`define PBD_MAP_SVH

// register indices; byte address is four times the index
`define PBD_IDX_MOD_B   4'h0
`define PBD_IDX_DTM_B   4'h1
`define PBD_IDX_ENC_C   4'h2
`define PBD_IDX_CFG     4'h3
`define PBD_IDX_MOD_C   4'h4
`define PBD_IDX_VAL4    4'h5
`define PBD_IDX_VAL5    4'h6
`define PBD_IDX_STS     4'h7
`define PBD_IDX_MSK     4'h8
`define PBD_IDX_CNT_C   4'h9
`define PBD_IDX_LAST    4'h9

// enable/control c field positions
`define PBD_ENC_EN      7
`define PBD_ENC_GLD     6
`define PBD_ENC_RST     2
`define PBD_ENC_LDOK    1
`define PBD_ENC_RIE     0

// configuration register field positions
`define PBD_CFG_MTG     0
`define PBD_CFG_WP      1
`define PBD_CFG_PRSC    2
`define PBD_CFG_SWCTL   4
`define PBD_CFG_SWVAL   6

// status and mask bit positions
`define PBD_STS_RF_C    0
`define PBD_STS_LD_B    1

// widths and reset values
`define PBD_MOD_W       15
`define PBD_DTM_W       12
`define PBD_DTM_B_RST   12'hFFF
`define PBD_AXI_OKAY    2'h0
`define PBD_AXI_SLVERR  2'h2

`endif

// >>> core/pbd_pkg.sv
// state types of the pwm buffer block
package pbd_pkg;

   // prescaler state
   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } pbd_psc_s;

   // main block state
   typedef struct packed {
      logic              aw_got;
      logic [7:0]        aw_addr;
      logic              w_got;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic              berr;
      logic              rvalid;
      logic              rerr;
      logic [31:0]       rdata;
      logic              multi_timebase_select;
      logic              wp;
      logic [1:0]        presc_buf;
      logic [1:0]        presc_act;
      logic [1:0]        sw_ctl;
      logic [1:0]        sw_val;
      logic [14:0]       mod_b_buf;
      logic [14:0]       mod_b_act;
      logic [11:0]       dtm_b;
      logic              en_c;
      logic              gld_c;
      logic              rst_c;
      logic              ldok_c;
      logic              rie_c;
      logic              ldok_arm;
      logic              rf_arm;
      logic [14:0]       mod_c_buf;
      logic [14:0]       mod_c_act;
      logic [1:0][14:0]  val_buf;
      logic [1:0][14:0]  val_act;
      logic [14:0]       cnt_c;
      logic              fresh;
      logic [1:0]        sts;
      logic [1:0]        msk;
      logic [1:0]        pwm;
   } pbd_state_s;

endpackage

// >>> core/pbd_prescale.sv
// pwm clock enable divider: one-cycle tick every 1, 2, 4 or 8 core cycles
module pbd_prescale (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       clear,
   input  wire logic [1:0] div_code,
   output logic            tick
);
   pbd_pkg::pbd_psc_s s_q;
   pbd_pkg::pbd_psc_s s_d;
   logic [2:0]        mask;

   // divide by two to the power of the code
   always_comb begin
      mask = 3'(4'h1 << div_code) - 3'h1;
      s_d = s_q;
      s_d.cnt = clear ? 3'h0 : s_q.cnt + 3'h1;
      s_d.tick = ~clear & ((s_q.cnt & mask) == mask);
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// >>> core/pbd_top.sv
// buffered period and unbuffered deadtime of generator b, generator c enable/control, axi4-lite slave
`include "pbd_map.svh"
module pbd_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   input  wire logic        load_ok_b,
   input  wire logic        load_cycle_b,
   input  wire logic        global_load_ok,
   input  wire logic        commutation_event,
   output logic [14:0]      period_modulus_b_active,
   output logic [11:0]      deadtime_count_b_out,
   output logic             pwm_output_four,
   output logic             pwm_output_five,
   output logic             irq
);
   pbd_pkg::pbd_state_s s_q;
   pbd_pkg::pbd_state_s s_d;
   logic                tick_c;
   logic                reload_c;
   logic                wrap_c;
   logic                load_go;
   logic                wr_go;
   logic                rd_go;
   logic [4:0]          wsel;
   logic [4:0]          rsel;
   logic [31:0]         wv;
   logic [7:0]          wc;
   logic [1:0]          pwm_next;

   ////////////////////////////////////////////////////////////////////////////////////
   // decode: {mapped, index}
   function automatic logic [4:0] reg_sel(input logic [7:0] addr);
      logic [3:0] idx;
      idx = addr[5:2];
      return {(addr[7:6] == 2'h0) && (idx <= `PBD_IDX_LAST), idx};
   endfunction

   // register read value, multi-timebase gating applied
   function automatic logic [31:0] rd_val(input pbd_pkg::pbd_state_s s, input logic [3:0] idx);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (idx)
         `PBD_IDX_MOD_B: v = s.multi_timebase_select ? 32'(s.mod_b_buf) : 32'h0000_0000;
         `PBD_IDX_DTM_B: v = s.multi_timebase_select ? 32'(s.dtm_b) : 32'h0000_0000;
         `PBD_IDX_ENC_C: v = s.multi_timebase_select ? {24'h00_0000, s.en_c, s.gld_c, 3'h0, s.rst_c, s.ldok_c,
                                      s.rie_c} : 32'h0000_0000;
         `PBD_IDX_CFG:   v = {24'h00_0000, s.sw_val, s.sw_ctl, s.presc_buf, s.wp, s.multi_timebase_select};
         `PBD_IDX_MOD_C: v = s.multi_timebase_select ? 32'(s.mod_c_buf) : 32'h0000_0000;
         `PBD_IDX_VAL4:  v = 32'(s.val_buf[0]);
         `PBD_IDX_VAL5:  v = 32'(s.val_buf[1]);
         `PBD_IDX_STS:   v = 32'(s.sts);
         `PBD_IDX_MSK:   v = 32'(s.msk);
         `PBD_IDX_CNT_C: v = s.multi_timebase_select ? 32'(s.cnt_c) : 32'h0000_0000;
         default:        v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // byte-lane merge of write data into the current value
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////
   // generator c pwm clock enable
   pbd_prescale u_psc (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .clear    (~s_q.en_c),
      .div_code (s_q.presc_act),
      .tick     (tick_c)
   );

   // output compare per channel, software control overrides
   for (genvar g = 0; g < 2; g++) begin : g_out
      assign pwm_next[g] = s_q.sw_ctl[g] ? s_q.sw_val[g]
                         : (s_q.en_c & (s_q.cnt_c < s_q.val_act[g]));
   end

   // cycle end and reload of generator c
   assign wrap_c   = (s_q.mod_c_act <= 15'h0001) ? 1'b1
                   : (s_q.cnt_c >= s_q.mod_c_act - 15'h0001);
   assign reload_c = s_q.en_c & tick_c & (s_q.fresh | wrap_c);
   assign load_go  = s_q.gld_c ? global_load_ok : s_q.ldok_c;

   assign wr_go = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
   assign rd_go = arvalid & ~s_q.rvalid;
   assign wsel  = reg_sel(s_q.aw_addr);
   assign rsel  = reg_sel(araddr);
   assign wv    = wmerge(rd_val(s_q, wsel[3:0]), s_q.w_data, s_q.w_strb);
   assign wc    = s_q.w_data[7:0] & {8{s_q.w_strb[0]}};

   ////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      // bus channels
      if (awvalid & awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid & wready) begin
         s_d.w_got = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid & bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid & rready) begin
         s_d.rvalid = 1'b0;
      end
      // read with its arming side effects
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rerr = ~rsel[4];
         s_d.rdata = rsel[4] ? rd_val(s_q, rsel[3:0]) : 32'h0000_0000;
         if (rsel[4] && rsel[3:0] == `PBD_IDX_STS && s_q.sts[`PBD_STS_RF_C]) begin
            s_d.rf_arm = 1'b1;
         end
         if (rsel[4] && rsel[3:0] == `PBD_IDX_ENC_C && s_q.multi_timebase_select && !s_q.ldok_c) begin
            s_d.ldok_arm = 1'b1;
         end
      end
      // generator b buffered modulus
      if (load_cycle_b & (load_ok_b | global_load_ok)) begin
         s_d.mod_b_act = s_q.mod_b_buf;
      end
      // generator c counter
      if (!s_q.en_c) begin
         s_d.cnt_c = 15'h0000;
         s_d.fresh = 1'b1;
      end else if (tick_c) begin
         s_d.cnt_c = reload_c ? 15'h0000 : s_q.cnt_c + 15'h0001;
         s_d.fresh = 1'b0;
      end
      if (s_q.en_c & s_q.rst_c & commutation_event) begin
         s_d.fresh = 1'b1;
      end
      // buffered values move in at reload
      if (reload_c & load_go) begin
         s_d.presc_act = s_q.presc_buf;
         s_d.mod_c_act = s_q.mod_c_buf;
         s_d.val_act = s_q.val_buf;
         if (!s_q.gld_c) begin
            s_d.ldok_c = 1'b0;
         end
      end
      // register write
      if (wr_go) begin
         s_d.bvalid = 1'b1;
         s_d.berr = ~wsel[4];
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         if (wsel[4]) begin
            case (wsel[3:0])
               `PBD_IDX_MOD_B: begin
                  if (s_q.multi_timebase_select) begin
                     s_d.mod_b_buf = wv[14:0];
                  end
               end
               `PBD_IDX_DTM_B: begin
                  if (s_q.multi_timebase_select && !s_q.wp) begin
                     s_d.dtm_b = wv[11:0];
                  end
               end
               `PBD_IDX_ENC_C: begin
                  if (s_q.multi_timebase_select) begin
                     s_d.en_c = wv[`PBD_ENC_EN];
                     s_d.rie_c = wv[`PBD_ENC_RIE];
                     if (!s_q.wp) begin
                        s_d.gld_c = wv[`PBD_ENC_GLD];
                        s_d.rst_c = wv[`PBD_ENC_RST];
                     end
                     if (!wv[`PBD_ENC_LDOK]) begin
                        s_d.ldok_c = 1'b0;
                     end else if (s_q.ldok_arm) begin
                        s_d.ldok_c = 1'b1;
                     end
                     s_d.ldok_arm = 1'b0;
                  end
               end
               `PBD_IDX_CFG: begin
                  s_d.multi_timebase_select = wv[`PBD_CFG_MTG];
                  s_d.wp = s_q.wp | wv[`PBD_CFG_WP];
                  s_d.presc_buf = wv[`PBD_CFG_PRSC +: 2];
                  s_d.sw_ctl = wv[`PBD_CFG_SWCTL +: 2];
                  s_d.sw_val = wv[`PBD_CFG_SWVAL +: 2];
               end
               `PBD_IDX_MOD_C: begin
                  if (s_q.multi_timebase_select) begin
                     s_d.mod_c_buf = wv[14:0];
                  end
               end
               `PBD_IDX_VAL4: s_d.val_buf[0] = wv[14:0];
               `PBD_IDX_VAL5: s_d.val_buf[1] = wv[14:0];
               `PBD_IDX_STS: begin
                  if (wc[`PBD_STS_LD_B]) begin
                     s_d.sts[`PBD_STS_LD_B] = 1'b0;
                  end
                  if (wc[`PBD_STS_RF_C] && s_q.rf_arm) begin
                     s_d.sts[`PBD_STS_RF_C] = 1'b0;
                  end
                  s_d.rf_arm = 1'b0;
               end
               `PBD_IDX_MSK: s_d.msk = wv[1:0];
               default: s_d.berr = s_q.berr & 1'b0;
            endcase
         end
      end
      // hardware events win over software clears
      if (reload_c) begin
         s_d.sts[`PBD_STS_RF_C] = 1'b1;
         s_d.rf_arm = 1'b0;
      end
      if (load_cycle_b) begin
         s_d.sts[`PBD_STS_LD_B] = 1'b1;
      end
      // generator c enable, load-ok and reload interrupt enable held at zero without multi-timebase
      if (!s_d.multi_timebase_select) begin
         s_d.en_c = 1'b0;
         s_d.ldok_c = 1'b0;
         s_d.rie_c = 1'b0;
         s_d.ldok_arm = 1'b0;
      end
      s_d.pwm = pwm_next;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.dtm_b <= `PBD_DTM_B_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign awready = ~s_q.aw_got & ~s_q.bvalid;
   assign wready  = ~s_q.w_got & ~s_q.bvalid;
   assign bvalid  = s_q.bvalid;
   assign bresp   = s_q.berr ? `PBD_AXI_SLVERR : `PBD_AXI_OKAY;
   assign arready = ~s_q.rvalid;
   assign rvalid  = s_q.rvalid;
   assign rdata   = s_q.rdata;
   assign rresp   = s_q.rerr ? `PBD_AXI_SLVERR : `PBD_AXI_OKAY;
   assign period_modulus_b_active = s_q.mod_b_act;
   assign deadtime_count_b_out    = s_q.dtm_b;
   assign pwm_output_four = s_q.pwm[0];
   assign pwm_output_five = s_q.pwm[1];
   // reload flag reaches the interrupt only with its enable
   assign irq = |(s_q.sts & s_q.msk & {1'b1, s_q.rie_c});

   ////////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_MTG_B_READ: assert property (
      (rd_go && rsel == {1'b1, `PBD_IDX_MOD_B} && !s_q.multi_timebase_select) |=> (rvalid && rdata == 32'h0000_0000))
      else $error("modulus b read nonzero without multi-timebase");
   AST_MOD_B_HOLD: assert property (
      !(load_cycle_b && (load_ok_b || global_load_ok)) |=> $stable(period_modulus_b_active))
      else $error("modulus b changed outside a load cycle");
   AST_DTM_RESET: assert property (
      $rose(aresetn) |-> deadtime_count_b_out == `PBD_DTM_B_RST)
      else $error("deadtime b not at maximum after reset");
   AST_DTM_LOCK: assert property (
      s_q.wp |=> $stable(deadtime_count_b_out))
      else $error("deadtime b changed while locked");
   AST_C_LOCK: assert property (
      s_q.wp |=> ($stable(s_q.gld_c) && $stable(s_q.rst_c)))
      else $error("locked generator c control changed");
   AST_OUT_OFF: assert property (
      (!s_q.en_c && !s_q.sw_ctl[0]) |=> !pwm_output_four)
      else $error("output four active while generator c disabled");
   AST_FIRST_RELOAD: assert property (
      $rose(s_q.en_c) |-> ##[1:8] (reload_c || !s_q.en_c))
      else $error("no reload at first cycle after enable");
   AST_LDOK_CLEAR: assert property (
      (reload_c && s_q.ldok_c && !s_q.gld_c && !wr_go) |=> !s_q.ldok_c)
      else $error("load-ok c not cleared after load");
   AST_IRQ_GATE: assert property (
      (!s_q.rie_c && !(s_q.sts[`PBD_STS_LD_B] && s_q.msk[`PBD_STS_LD_B])) |-> !irq)
      else $error("interrupt raised with reload enable clear");
   AST_MTG_C_ZERO: assert property (
      !s_q.multi_timebase_select |-> !(s_q.en_c || s_q.ldok_c || s_q.rie_c))
      else $error("generator c control set without multi-timebase");
   AST_RF_SET: assert property (
      reload_c |=> s_q.sts[`PBD_STS_RF_C] [*2])
      else $error("reload flag lost after reload");

   COV_LOAD_C: cover property (reload_c && load_go);
   COV_LOAD_B: cover property (load_cycle_b && load_ok_b ##1 period_modulus_b_active != 15'h0000);
   COV_IRQ: cover property ($rose(irq));
endmodule

// >>> dv/pbd_stage_model.sv
// power stage model: measures period and high time of output four, watches output five
module pbd_stage_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pwm_output_four,
   input  wire logic pwm_output_five,
   output int        period_four,
   output int        high_four,
   output logic      seen_five
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q;
   int   cnt_q;
   int   hi_q;
   // a rising edge of output four closes one measured period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_q <= 1'b0;
         cnt_q <= 0;
         hi_q <= 0;
         period_four <= 0;
         high_four <= 0;
         seen_five <= 1'b0;
      end else begin
         last_q <= pwm_output_four;
         if (pwm_output_five === 1'b1) begin
            seen_five <= 1'b1;
         end
         if (pwm_output_four === 1'b1 && last_q !== 1'b1) begin
            period_four <= cnt_q;
            high_four <= hi_q;
            cnt_q <= 1;
            hi_q <= 1;
         end else begin
            cnt_q <= cnt_q + 1;
            hi_q <= hi_q + ((pwm_output_four === 1'b1) ? 1 : 0);
         end
      end
   end
endmodule

// >>> dv/pbd_top_tb.sv
// self-checking bench of the pwm buffer block
`include "pbd_map.svh"
module pbd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] i_modb = `PBD_IDX_MOD_B, i_dtm = `PBD_IDX_DTM_B;
   localparam logic [3:0] i_enc = `PBD_IDX_ENC_C, i_cfg = `PBD_IDX_CFG;
   localparam logic [3:0] i_modc = `PBD_IDX_MOD_C, i_v4 = `PBD_IDX_VAL4;
   localparam logic [3:0] i_v5 = `PBD_IDX_VAL5, i_sts = `PBD_IDX_STS;
   localparam logic [3:0] i_msk = `PBD_IDX_MSK, i_cnt = `PBD_IDX_CNT_C;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq, seen_five;
   logic        load_ok_b, load_cycle_b, global_load_ok, commutation_event;
   logic        pwm_output_four, pwm_output_five;
   logic [7:0]  awaddr, araddr;
   logic [2:0]  awprot, arprot;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rd_resp, wresp;
   logic [14:0] period_modulus_b_active;
   logic [11:0] deadtime_count_b_out;
   int          period_four, high_four, n_mismatch, compares, cyc;

   pbd_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
      .rvalid, .rready, .rdata, .rresp, .load_ok_b, .load_cycle_b, .global_load_ok,
      .commutation_event, .period_modulus_b_active, .deadtime_count_b_out,
      .pwm_output_four, .pwm_output_five, .irq);
   pbd_stage_model stage (.aclk, .aresetn, .pwm_output_four, .pwm_output_five,
      .period_four, .high_four, .seen_five);

   // core clock, 5 ns period
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // bus master: requests held until ready is sampled, answers taken at that edge
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = bvalid & bready;
         wresp = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
      end
   endtask

   task automatic rd(input logic [3:0] idx);
      logic ar_hs, r_hs;
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         r_hs = rvalid & rready;
         rd_data = rdata;
         rd_resp = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
      end
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   // generator b registers: gating, buffering, deadtime, bus errors
   task automatic t_regs_b();
      @(negedge aclk);
      chk("deadtime out", 32'h0000_0fff, 32'(deadtime_count_b_out));
      @(posedge aclk);
      wr(i_modb, 32'h0000_0055);
      wr(i_enc, 32'h0000_0083);
      rd(i_dtm);
      chk("deadtime gated", 32'h0000_0000, rd_data);
      rd(i_modb);
      chk("modulus b gated", 32'h0000_0000, rd_data);
      rd(4'hf);
      chk("unmapped read", 32'(`PBD_AXI_SLVERR), 32'(rd_resp));
      wr(4'hf, 32'h0000_0001);
      chk("unmapped write", 32'(`PBD_AXI_SLVERR), 32'(wresp));
      wr(i_cfg, 32'h0000_0001);
      rd(i_modb);
      chk("modulus b ignored", 32'h0000_0000, rd_data);
      rd(i_enc);
      chk("control c ignored", 32'h0000_0000, rd_data);
      rd(i_dtm);
      chk("deadtime reset", 32'h0000_0fff, rd_data);
      wr(i_modb, 32'h0000_7abc);
      rd(i_modb);
      chk("modulus b buffer", 32'h0000_7abc, rd_data);
      load_cycle_b <= 1'b1;
      @(posedge aclk);
      load_cycle_b <= 1'b0;
      @(negedge aclk);
      chk("modulus b held", 32'h0000_0000, 32'(period_modulus_b_active));
      @(posedge aclk);
      load_ok_b <= 1'b1;
      load_cycle_b <= 1'b1;
      @(posedge aclk);
      load_cycle_b <= 1'b0;
      load_ok_b <= 1'b0;
      @(negedge aclk);
      chk("modulus b loaded", 32'h0000_7abc, 32'(period_modulus_b_active));
      @(posedge aclk);
      // lane 0 only: upper byte of the buffer must survive
      wstrb <= 4'h1;
      wr(i_modb, 32'h0000_0011);
      wstrb <= 4'hf;
      rd(i_modb);
      chk("modulus b lane", 32'h0000_7a11, rd_data);
      wr(i_dtm, 32'h0000_0123);
      rd(i_dtm);
      chk("deadtime read", 32'h0000_0123, rd_data);
      chk("deadtime out", 32'h0000_0123, 32'(deadtime_count_b_out));
      $display("test regs_b done");
   endtask

   // generator c: load-ok handshake, prescaler codes, reload flag and interrupt
   task automatic t_gen_c();
      wr(i_modc, 32'h0000_000a);
      wr(i_v4, 32'h0000_0005);
      wr(i_v5, 32'h0000_0003);
      rd(i_enc);
      wr(i_enc, 32'h0000_0002);
      rd(i_enc);
      chk("load-ok set", 32'h0000_0002, rd_data);
      wr(i_enc, 32'h0000_0000);
      rd(i_enc);
      chk("load-ok cleared", 32'h0000_0000, rd_data);
      for (int code = 0; code < 4; code++) begin
         wr(i_cfg, 32'(code * 4 + 1));
         rd(i_enc);
         if (code == 0) wr(i_enc, 32'h0000_0003);
         wr(i_enc, 32'h0000_0083);
         repeat (250) @(posedge aclk);
         rd(i_enc);
         chk("load-ok after load", 32'h0000_0081, rd_data);
         chk("period four", 32'(10 << code), 32'(period_four));
         chk("high four", 32'(5 << code), 32'(high_four));
      end
      chk("output five ran", 32'h0000_0001, 32'(seen_five));
      wr(i_msk, 32'h0000_0001);
      rd(i_sts);
      chk("reload flag", 32'h0000_0001, rd_data & 32'h0000_0001);
      chk("irq raised", 32'h0000_0001, 32'(irq));
      repeat (100) @(posedge aclk);
      wr(i_sts, 32'h0000_0001);
      rd(i_sts);
      chk("flag kept", 32'h0000_0001, rd_data & 32'h0000_0001);
      wr(i_enc, 32'h0000_0001);
      wr(i_enc, 32'h0000_0000);
      chk("irq gated", 32'h0000_0000, 32'(irq));
      chk("four idle", 32'h0000_0000, 32'(pwm_output_four));
      wr(i_cfg, 32'h0000_0051);
      @(negedge aclk);
      chk("four forced", 32'h0000_0001, 32'(pwm_output_four));
      chk("five idle", 32'h0000_0000, 32'(pwm_output_five));
      @(posedge aclk);
      rd(i_sts);
      wr(i_sts, 32'h0000_0001);
      rd(i_sts);
      chk("flag cleared", 32'h0000_0000, rd_data & 32'h0000_0001);
      wr(i_enc, 32'h0000_0081);
      wr(i_cfg, 32'h0000_0000);
      wr(i_cfg, 32'h0000_0001);
      rd(i_enc);
      chk("cleared by mtg", 32'h0000_0000, rd_data & 32'h0000_0083);
      $display("test gen_c done");
   endtask

   // global load, restart on commutation, write-protect lock
   task automatic t_global_lock();
      wr(i_modc, 32'h0000_0014);
      wr(i_enc, 32'h0000_0040);
      global_load_ok <= 1'b1;
      wr(i_enc, 32'h0000_00c0);
      repeat (120) @(posedge aclk);
      chk("global period", 32'h0000_0014, 32'(period_four));
      wr(i_modc, 32'h0000_7fff);
      wr(i_enc, 32'h0000_00c4);
      repeat (300) @(posedge aclk);
      rd(i_cnt);
      chk("counter running", 32'h0000_0001, 32'(rd_data > 100));
      commutation_event <= 1'b1;
      @(posedge aclk);
      commutation_event <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(i_cnt);
      chk("counter restarted", 32'h0000_0001, 32'(rd_data < 16));
      wr(i_cfg, 32'h0000_0003);
      wr(i_dtm, 32'h0000_0456);
      rd(i_dtm);
      chk("deadtime locked", 32'h0000_0123, rd_data);
      chk("deadtime out locked", 32'h0000_0123, 32'(deadtime_count_b_out));
      wr(i_enc, 32'h0000_0080);
      rd(i_enc);
      chk("selects locked", 32'h0000_0044, rd_data & 32'h0000_0044);
      $display("test global_lock done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      cyc = 0;
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
         end
      end
   end

   // main sequence
   initial begin
      {awvalid, wvalid, arvalid} = '0;
      // responses are always accepted, so ready never toggles between transfers
      bready = 1'b1;
      rready = 1'b1;
      {load_ok_b, load_cycle_b, global_load_ok, commutation_event} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      awprot = '0;
      arprot = '0;
      aresetn = 1'b0;
      n_mismatch = 0;
      compares = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs_b();
      t_gen_c();
      t_global_lock();
      print_verdict();
   end
endmodule
